/* File: verilog/blf_fade_level.sv */
// Backlight fade sequencer with level 1 and level 2 max and dim current registers.
// Assumes a synchronous byte-wide register port driven by an I2C slave on ref_clk.
//
// Operation
// - Nonzero fade-out code ramps current down to dim or off target.
// - Fade-out code sets full-scale time: 0.3 s steps to 3.0, then 0.5 s steps.
// - Code zero moves current to target immediately, within 100 ms.
// - Turning on with nonzero fade-in code ramps current up to maximum.
// - Fade-in uses the same encoding, referenced to 0 to 30 mA.
// - Per-step rate is fixed, so shorter fades finish sooner.
// - Level 1 maximum register holds 7-bit code, bit 7 reserved.
// - Code maps to current by square law, 0x7f gives 30 mA.
// - Cubic laws share the mapping and only change time per code.
// - Dim code applies on dim timeout or when dim enable is set.
// - Level 2 has max code at 0x0c and dim code at 0x0d.
// - Level 1 has dim code at 0x0b separate from max at 0x0a.
// - Level field selects level 1 or 2; values 101 to 111 force zero.
// - Law field 00/01 gives linear steps, 10/11 give cubic steps.
// - Dim timeout starts only after maximum is reached.
`timescale 1ns/1ps
module blf_fade_level
    import blf_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // Register port.
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_ff,
    // Controls from neighbouring registers and timers.
    input wire logic backlight_on,
    input wire logic dim_enable,
    input wire logic dim_timeout_expired,
    input wire logic [2:0] brightness_level_select,
    input wire logic [1:0] ramp_transfer_law,
    // DAC drive and status.
    output logic [6:0] dac_code_ff,
    output logic at_max_ff,
    output logic ramping_ff
);
    // ==========================================================
    // Registers
    logic [7:0] fade_ff;
    logic [6:0] l1_max_ff, l1_dim_ff, l2_max_ff, l2_dim_ff;
    wire logic [3:0] fade_out_rate = fade_ff[7:4];
    wire logic [3:0] fade_in_rate = fade_ff[3:0];
    wire logic [6:0] wcode = reg_wdata[6:0] & CODE_MASK[6:0];

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            fade_ff <= RESET_VALUE;
            l1_max_ff <= CODE_ZERO;
            l1_dim_ff <= CODE_ZERO;
            l2_max_ff <= CODE_ZERO;
            l2_dim_ff <= CODE_ZERO;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_FADE) fade_ff <= reg_wdata;
            if (reg_addr == ADDR_L1_MAX) l1_max_ff <= wcode;
            if (reg_addr == ADDR_L1_DIM) l1_dim_ff <= wcode;
            if (reg_addr == ADDR_L2_MAX) l2_max_ff <= wcode;
            if (reg_addr == ADDR_L2_DIM) l2_dim_ff <= wcode;
        end
    end

    // Unmapped addresses read zero; reserved bit 7 of code registers reads zero.
    logic [7:0] nxt_rdata;
    always_comb begin
        unique case (reg_addr)
            ADDR_FADE: nxt_rdata = fade_ff;
            ADDR_L1_MAX: nxt_rdata = {1'b0, l1_max_ff};
            ADDR_L1_DIM: nxt_rdata = {1'b0, l1_dim_ff};
            ADDR_L2_MAX: nxt_rdata = {1'b0, l2_max_ff};
            ADDR_L2_DIM: nxt_rdata = {1'b0, l2_dim_ff};
            default: nxt_rdata = RESET_VALUE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) reg_rdata_ff <= RESET_VALUE;
        else if (reg_rd) reg_rdata_ff <= nxt_rdata;
    end

    // ==========================================================
    // Target selection
    wire logic lvl_one = brightness_level_select == LEVEL_ONE;
    wire logic lvl_two = brightness_level_select == LEVEL_TWO;
    wire logic lvl_off = brightness_level_select >= LEVEL_OFF_FIRST;
    // Levels 3 to 5 are served elsewhere; here they fall back to level 1 codes.
    wire logic [6:0] sel_max = lvl_two ? l2_max_ff : l1_max_ff;
    wire logic [6:0] sel_dim = lvl_two ? l2_dim_ff : l1_dim_ff;
    // The dim timer counts only at maximum; its expiry is held here, because the
    // first step away from maximum would otherwise withdraw the request and bounce.
    logic dim_hold_ff;
    wire logic dim_req = dim_enable ||
                         (dim_timeout_expired && (at_max_ff || dim_hold_ff));

    always_ff @(posedge ref_clk) begin
        if (!reset_n) dim_hold_ff <= 1'b0;
        else dim_hold_ff <= backlight_on && dim_timeout_expired && (at_max_ff || dim_hold_ff);
    end
    wire logic [6:0] target = (!backlight_on || lvl_off) ? CODE_ZERO :
                              (dim_req ? sel_dim : sel_max);
    wire logic going_up = target > dac_code_ff;
    wire logic [3:0] rate = going_up ? fade_in_rate : fade_out_rate;

    // ==========================================================
    // Step timing: full-scale time spread over 127 codes, a fixed time per code.
    function automatic logic [CNT_W-1:0] step_cycles(input logic [3:0] r);
        int ms;
        ms = 0;
        if (r == RATE_OFF) ms = INSTANT_MS;
        else if (r <= RATE_LIN_LAST) ms = int'(r) * STEP_MS_SHORT;
        else ms = BASE_MS_LONG + (int'(r) - LIN_LAST) * STEP_MS_LONG;
        step_cycles = CNT_W'(ms * CYC_PER_MS / CODE_STEPS);
    endfunction : step_cycles

    // Cubic laws dwell longer near the dark end and shorter near full scale,
    // keeping an average near the linear figure; Cubic 11 is the stronger bend.
    logic [CNT_W-1:0] base_cyc, dwell_cyc;
    always_comb begin
        base_cyc = step_cycles(rate);
        unique case (ramp_transfer_law)
            // Products are formed at 32 bits; a long dwell times a code overflows CNT_W.
            LAW_CUBIC_10: dwell_cyc = base_cyc + (base_cyc >> 1) -
                                      CNT_W'((32'(base_cyc) * 32'(dac_code_ff)) >> 7);
            LAW_CUBIC_11: dwell_cyc = (base_cyc << 1) -
                                      CNT_W'((32'(base_cyc) * 32'(dac_code_ff)) >> 6);
            default: dwell_cyc = base_cyc;
        endcase
        if (dwell_cyc == '0) dwell_cyc = CNT_W'(1);
    end

    // ==========================================================
    // Sequencer
    blf_state_t state_ff;
    logic [CNT_W-1:0] cnt_ff;
    // A step falls on the dwell's last cycle, so a full-scale fade is 127 dwells.
    wire logic step_due = (cnt_ff + CNT_W'(1)) >= dwell_cyc;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_ff <= ST_IDLE;
            cnt_ff <= '0;
            dac_code_ff <= CODE_ZERO;
            ramping_ff <= 1'b0;
            at_max_ff <= 1'b0;
        end else begin
            at_max_ff <= backlight_on && !lvl_off && (dac_code_ff == sel_max);
            unique case (state_ff)
                ST_IDLE, ST_HOLD: begin
                    cnt_ff <= '0;
                    ramping_ff <= target != dac_code_ff;
                    state_ff <= (target != dac_code_ff) ? ST_RAMP : ST_HOLD;
                end
                ST_RAMP: begin
                    if (target == dac_code_ff) begin
                        state_ff <= ST_HOLD;
                        ramping_ff <= 1'b0;
                        cnt_ff <= '0;
                    end else if (step_due) begin
                        // One code per dwell keeps the rate fixed per step.
                        cnt_ff <= '0;
                        dac_code_ff <= going_up ? dac_code_ff + 7'h01
                                                : dac_code_ff - 7'h01;
                    end else begin
                        cnt_ff <= cnt_ff + CNT_W'(1);
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Checks
    a_code_moves_one: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $changed(dac_code_ff) |->
        (dac_code_ff == $past(dac_code_ff) + 7'h01 ||
         dac_code_ff == $past(dac_code_ff) - 7'h01))
        else $error("dac code jumped by more than one");
    a_reserved_reads_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (reg_rd && reg_addr >= ADDR_L1_MAX && reg_addr <= ADDR_L2_DIM) |=>
        !reg_rdata_ff[7])
        else $error("reserved bit read as one");
    // A fade write, one edge without a write, then a read of the same register.
    sequence s_fade_write;
        reg_wr && reg_addr == ADDR_FADE;
    endsequence
    sequence s_fade_read_back;
        !reg_wr ##1 (reg_rd && !reg_wr && reg_addr == ADDR_FADE);
    endsequence
    a_fade_readback: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_fade_write ##1 s_fade_read_back |=> reg_rdata_ff == $past(reg_wdata, 3))
        else $error("fade register readback mismatch");
    a_l2_max_store: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (reg_wr && reg_addr == ADDR_L2_MAX) |=> l2_max_ff == $past(reg_wdata[6:0]))
        else $error("level two max not stored");
    a_l1_dim_store: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (reg_wr && reg_addr == ADDR_L1_DIM) |=> l1_dim_ff == $past(reg_wdata[6:0]))
        else $error("level one dim not stored");
    a_off_level_down: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (lvl_off && dac_code_ff != CODE_ZERO && state_ff == ST_RAMP) |=>
        dac_code_ff <= $past(dac_code_ff))
        else $error("code rose while level forces zero");
    a_ramp_starts: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state_ff == ST_HOLD && target != dac_code_ff) |=> state_ff == ST_RAMP)
        else $error("ramp did not start");
    a_at_max_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
        at_max_ff |-> $past(backlight_on) && !$past(lvl_off))
        else $error("at max without backlight on");
    a_dim_after_max: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $rose(dim_hold_ff) |-> $past(at_max_ff))
        else $error("dim hold set before maximum was reached");
    a_level_one_codes: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (lvl_one && backlight_on && !dim_req) |-> target == l1_max_ff)
        else $error("level one maximum code not selected");
    // Both cubic laws dwell longer than linear in the lower half of the code range.
    a_cubic_dark_slow: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (ramp_transfer_law[1] && !dac_code_ff[6]) |-> dwell_cyc > base_cyc)
        else $error("cubic dwell not longer near the dark end");
    a_linear_dwell: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !ramp_transfer_law[1] |-> dwell_cyc == base_cyc)
        else $error("linear law dwell differs from base");
endmodule : blf_fade_level

/* File: verilog/blf_pkg.sv */
// Package for the backlight fade and level current block.
// Assumes a 50 MHz ref_clk and an 8-bit register port from an I2C front end.
package blf_pkg;
    localparam logic [7:0] ADDR_FADE = 8'h09;
    localparam logic [7:0] ADDR_L1_MAX = 8'h0a;
    localparam logic [7:0] ADDR_L1_DIM = 8'h0b;
    localparam logic [7:0] ADDR_L2_MAX = 8'h0c;
    localparam logic [7:0] ADDR_L2_DIM = 8'h0d;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam logic [7:0] CODE_MASK = 8'h7f;
    localparam logic [6:0] CODE_ZERO = 7'h00;
    localparam logic [6:0] CODE_FULL = 7'h7f;
    localparam logic [3:0] RATE_OFF = 4'h0;
    localparam logic [3:0] RATE_LIN_LAST = 4'ha;
    localparam logic [2:0] LEVEL_ONE = 3'h0;
    localparam logic [2:0] LEVEL_TWO = 3'h1;
    localparam logic [2:0] LEVEL_OFF_FIRST = 3'h5;
    localparam logic [1:0] LAW_CUBIC_10 = 2'h2;
    localparam logic [1:0] LAW_CUBIC_11 = 2'h3;
    localparam int CLK_HZ = 50000000;
    localparam int STEP_MS_SHORT = 300;
    localparam int STEP_MS_LONG = 500;
    localparam int BASE_MS_LONG = 3000;
    localparam int INSTANT_MS = 100;
    localparam int CODE_STEPS = 127;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int INSTANT_CYC = INSTANT_MS * CYC_PER_MS / CODE_STEPS;
    localparam int LIN_LAST = 10;
    localparam int CNT_W = 24;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RAMP = 2'b01,
        ST_HOLD = 2'b10
    } blf_state_t;
endpackage : blf_pkg

/* File: testbench/blf_host_model.sv */
// ==========================================
// Host model for the byte register port.
// Assumes one clock domain and that the bench calls its tasks one at a time.
`timescale 1ns/1ps
module blf_host_model (
    // Clock.
    ref_clk,
    // Register port.
    reg_wr,
    reg_rd,
    reg_addr,
    reg_wdata
);
    input wire logic ref_clk;
    output logic reg_wr = 1'b0;
    output logic reg_rd = 1'b0;
    output logic [7:0] reg_addr = 8'h00;
    output logic [7:0] reg_wdata = 8'h00;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        // A released data bus must not keep showing the last byte.
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
    endtask : rd
endmodule : blf_host_model

/* File: testbench/blf_fade_level_tb.sv */
// ==========================================
// Self-checking bench for the fade and level current block.
// Assumes the package constants give the step dwell of fade code zero.
`timescale 1ns/1ps
module blf_fade_level_tb;
    import blf_pkg::*;
    logic ref_clk, reset_n, reg_wr, reg_rd, backlight_on, dim_enable, dim_tmo, at_max, ramping;
    logic [7:0] reg_addr, reg_wdata, rdata, a, d;
    logic [2:0] level;
    logic [1:0] law;
    logic [6:0] dac;
    logic [7:0] exp_q[$];
    logic rd_seen = 1'b0;
    int num_errors = 0, n_checks = 0, cyc = 0, n;
    int seed;
    blf_host_model host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    blf_fade_level dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(rdata),
        .backlight_on(backlight_on), .dim_enable(dim_enable), .dim_timeout_expired(dim_tmo),
        .brightness_level_select(level), .ramp_transfer_law(law), .dac_code_ff(dac),
        .at_max_ff(at_max), .ramping_ff(ramping));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    task automatic wait_dac(input logic [6:0] code);
        n = 0;
        while (dac !== code && n < 2 * INSTANT_CYC) begin
            @(posedge ref_clk);
            n++;
        end
    endtask : wait_dac
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // Read data is taken one edge after the read request is sampled.
    always @(posedge ref_clk) begin
        if (rd_seen) check("read_data", rdata, exp_q.pop_front());
        rd_seen <= reg_rd;
        cyc++;
        // Two instant steps plus room for the register and level tests.
        if (cyc == 2 * INSTANT_CYC + 12000) begin
            num_errors++;
            final_report();
        end
    end
    initial begin
        seed = 32'h393b;
        reset_n <= 1'b0;
        backlight_on <= 1'b0;
        dim_enable <= 1'b0;
        dim_tmo <= 1'b0;
        level <= LEVEL_ONE;
        law <= 2'h0;
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        check("dac_reset", {1'b0, dac}, 8'h00);
        for (a = ADDR_FADE; a <= 8'h0e; a++) begin
            d = 8'($random(seed));
            host.wr(a, d);
            exp_q.push_back(a == ADDR_FADE ? d : (a < 8'h0e ? d & CODE_MASK : RESET_VALUE));
            host.rd(a);
        end
        repeat (3) @(posedge ref_clk);
        $display("register test done");
        host.wr(ADDR_FADE, 8'h00);
        host.wr(ADDR_L1_MAX, 8'h00);
        host.wr(ADDR_L2_MAX, 8'h81);
        host.wr(ADDR_L2_DIM, 8'h80);
        level <= LEVEL_TWO;
        backlight_on <= 1'b1;
        wait_dac(7'h01);
        check("dac_up", {1'b0, dac}, 8'h01);
        check("step_time", {7'h0, n > INSTANT_CYC - 16 && n < INSTANT_CYC + 16}, 8'h01);
        repeat (4) @(posedge ref_clk);
        check("at_max", {7'h0, at_max}, 8'h01);
        $display("ramp up test done");
        dim_enable <= 1'b1;
        law <= LAW_CUBIC_10;
        repeat (3) @(posedge ref_clk);
        check("dim_enable_ramp", {7'h0, ramping}, 8'h01);
        dim_enable <= 1'b0;
        law <= LAW_CUBIC_11;
        repeat (3) @(posedge ref_clk);
        check("dim_release", {7'h0, ramping}, 8'h00);
        check("max_again", {7'h0, at_max}, 8'h01);
        level <= LEVEL_OFF_FIRST;
        law <= 2'h0;
        repeat (3) @(posedge ref_clk);
        check("off_at_max", {7'h0, at_max}, 8'h00);
        check("off_ramp", {7'h0, ramping}, 8'h01);
        level <= LEVEL_ONE;
        repeat (3) @(posedge ref_clk);
        check("l1_at_max", {7'h0, at_max}, 8'h00);
        level <= LEVEL_TWO;
        repeat (3) @(posedge ref_clk);
        check("l2_at_max", {7'h0, at_max}, 8'h01);
        check("l2_hold", {7'h0, ramping}, 8'h00);
        check("dac_kept", {1'b0, dac}, 8'h01);
        $display("level test done");
        dim_tmo <= 1'b1;
        wait_dac(7'h00);
        check("dac_dim", {1'b0, dac}, 8'h00);
        check("dim_time", {7'h0, n > INSTANT_CYC - 16 && n < INSTANT_CYC + 16}, 8'h01);
        repeat (4) @(posedge ref_clk);
        check("ramp_end", {7'h0, ramping}, 8'h00);
        check("dim_held", {1'b0, dac}, 8'h00);
        $display("dim test done");
        final_report();
    end
endmodule : blf_fade_level_tb
